// >>> rtl/smsl_device.sv
// management slave: frame decoder and 32 x 16 register file
// assumes mdc and mdio are asynchronous pins; both pass two flip-flops
`timescale 1ns/1ps
module smsl_device
   import smsl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   smsl_if.device bus,
   input wire logic [STRAP_W-1:0] bus_address_straps,
   input wire logic [4:0] loc_addr,
   output logic [DATA_W-1:0] loc_rdata,
   input wire logic loc_we,
   input wire logic [DATA_W-1:0] loc_wdata,
   output logic wr_pulse,
   output logic [4:0] wr_addr,
   output logic [DATA_W-1:0] wr_data,
   output logic rd_pulse,
   output logic frame_drop,
   output logic [STRAP_W-1:0] own_addr,
   output logic addr_valid
);
   typedef enum {S_IDLE, S_START, S_HDR, S_TA, S_DATA} smsl_dst_t;

   logic mdc_m_r, mdc_s_r, mdc_d_r;
   logic dio_m_r, dio_s_r;
   logic [STRAP_W-1:0] strap_m_r, strap_s_r, addr_r;
   logic [1:0] cap_r;
   logic cap_done_r;
   logic [DATA_W-1:0] regs_r [NUM_REGS];
   logic [DATA_W-1:0] rdata_r;

   smsl_dst_t st_r, st_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [11:0] hdr_r, hdr_nxt;
   logic [DATA_W-1:0] sh_r, sh_nxt;
   logic rd_r, rd_nxt;
   logic hit_r, hit_nxt;
   logic ta1_r, ta1_nxt;
   logic oe_r, oe_nxt;
   logic out_r, out_nxt;
   logic wr_r, wr_nxt;
   logic rdp_r, rdp_nxt;
   logic drop_r, drop_nxt;

   wire mdc_rise = mdc_s_r & ~mdc_d_r;
   wire bit_in = dio_s_r;
   wire [11:0] hdr_sh = {hdr_r[10:0], bit_in};
   wire op_rd = (hdr_sh[11:10] == OP_READ);
   wire op_wr = (hdr_sh[11:10] == OP_WRITE);
   wire phy_hit = (hdr_sh[9:5] == {2'b00, addr_r});
   wire [4:0] reg_idx = hdr_sh[4:0];
   wire drive_rd = rd_r & hit_r;
   wire [1:0] ta_seen = {ta1_r, bit_in};
   wire loc_wr_ok = loc_we & ~wr_r;

   // synchronisers; first stages feed only second stages
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mdc_m_r <= 1'b0;
         mdc_s_r <= 1'b0;
         mdc_d_r <= 1'b0;
         dio_m_r <= 1'b1;
         dio_s_r <= 1'b1;
         strap_m_r <= '0;
         strap_s_r <= '0;
      end else begin
         mdc_m_r <= bus.mdc;
         mdc_s_r <= mdc_m_r;
         mdc_d_r <= mdc_s_r;
         dio_m_r <= bus.mdio_line;
         dio_s_r <= dio_m_r;
         strap_m_r <= bus_address_straps;
         strap_s_r <= strap_m_r;
      end
   end

   // straps are sampled for a few cycles after release, then frozen
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cap_r <= 2'h0;
         cap_done_r <= 1'b0;
         addr_r <= '0;
      end else if (!cap_done_r) begin
         addr_r <= strap_s_r;
         cap_r <= cap_r + 2'h1;
         cap_done_r <= (cap_r == STRAP_SETTLE);
      end
   end

   // the decoder advances only on seen mdc edges, so a stopped clock just parks it
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      hdr_nxt = hdr_r;
      sh_nxt = sh_r;
      rd_nxt = rd_r;
      hit_nxt = hit_r;
      ta1_nxt = ta1_r;
      oe_nxt = oe_r;
      out_nxt = out_r;
      wr_nxt = 1'b0;
      rdp_nxt = 1'b0;
      drop_nxt = 1'b0;
      if (mdc_rise && cap_done_r) begin
         case (st_r)
            S_IDLE: begin
               if (!bit_in) begin
                  st_nxt = S_START;
               end
            end
            S_START: begin
               if (bit_in) begin
                  st_nxt = S_HDR;
                  cnt_nxt = 5'h00;
               end
            end
            S_HDR: begin
               hdr_nxt = hdr_sh;
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == HDR_LAST) begin
                  cnt_nxt = 5'h00;
                  rd_nxt = op_rd;
                  hit_nxt = phy_hit;
                  sh_nxt = regs_r[reg_idx];
                  if (op_rd || op_wr) begin
                     st_nxt = S_TA;
                  end else begin
                     st_nxt = S_IDLE;
                     drop_nxt = 1'b1;
                  end
               end
            end
            S_TA: begin
               if (cnt_r == 5'h00) begin
                  // first read turnaround bit stays released; drive begins after it
                  cnt_nxt = 5'h01;
                  ta1_nxt = bit_in;
                  if (drive_rd) begin
                     oe_nxt = 1'b1;
                     out_nxt = 1'b0;
                  end
               end else begin
                  cnt_nxt = 5'h00;
                  st_nxt = S_DATA;
                  if (drive_rd) begin
                     out_nxt = sh_r[DATA_W-1];
                     sh_nxt = {sh_r[DATA_W-2:0], 1'b0};
                     rdp_nxt = 1'b1;
                  end else if (!rd_r && ta_seen != TA_WRITE) begin
                     // a write without a proper turnaround is not trusted
                     st_nxt = S_IDLE;
                     drop_nxt = 1'b1;
                  end
               end
            end
            S_DATA: begin
               cnt_nxt = cnt_r + 5'h01;
               if (rd_r) begin
                  out_nxt = sh_r[DATA_W-1];
                  sh_nxt = {sh_r[DATA_W-2:0], 1'b0};
               end else begin
                  sh_nxt = {sh_r[DATA_W-2:0], bit_in};
               end
               if (cnt_r == DATA_LAST) begin
                  st_nxt = S_IDLE;
                  oe_nxt = 1'b0;
                  wr_nxt = ~rd_r & hit_r;
               end
            end
            default: begin
               st_nxt = S_IDLE;
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         cnt_r <= 5'h00;
         hdr_r <= 12'h000;
         sh_r <= '0;
         rd_r <= 1'b0;
         hit_r <= 1'b0;
         ta1_r <= 1'b1;
         oe_r <= 1'b0;
         out_r <= 1'b1;
         wr_r <= 1'b0;
         rdp_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         hdr_r <= hdr_nxt;
         sh_r <= sh_nxt;
         rd_r <= rd_nxt;
         hit_r <= hit_nxt;
         ta1_r <= ta1_nxt;
         oe_r <= oe_nxt;
         out_r <= out_nxt;
         wr_r <= wr_nxt;
         rdp_r <= rdp_nxt;
         drop_r <= drop_nxt;
      end
   end

   // a management write wins over a local write in the same cycle; the local one is lost
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= REG_RESET;
         end
         rdata_r <= REG_RESET;
      end else begin
         if (wr_r) begin
            regs_r[hdr_r[4:0]] <= sh_r;
         end else if (loc_wr_ok) begin
            regs_r[loc_addr] <= loc_wdata;
         end
         rdata_r <= regs_r[loc_addr];
      end
   end

   assign bus.dv_out = out_r;
   assign bus.dv_oe = oe_r;
   assign loc_rdata = rdata_r;
   assign wr_pulse = wr_r;
   assign wr_addr = hdr_r[4:0];
   assign wr_data = sh_r;
   assign rd_pulse = rdp_r;
   assign frame_drop = drop_r;
   assign own_addr = addr_r;
   assign addr_valid = cap_done_r;
endmodule

// >>> rtl/smsl_pkg.sv
// constants shared by both ends of the two-wire serial management link
// assumes both ends run on one 125 MHz system clock domain each
// Functional notes
// - station supplies management clock; may stop when idle
// - receiver samples data on rising management clock
// - idle and first read turnaround bit: nobody drives, pull-up high
// - device answers only its own physical address
// - address straps captured at reset, then held
// - station idles one clock before first frame
// - register field indexes thirty-two sixteen-bit registers
// - frame starts only with zero then one
// - two turnaround bits precede sixteen data bits
// - read: nobody drives first turnaround bit
// - read: device drives zero, then register data
// - write: station drives one-zero turnaround, then data
package smsl_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MDC_PERIOD_NS = 80;
   localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int NUM_REGS = 32;
   localparam int DATA_W = 16;
   localparam int STRAP_W = 3;
   localparam logic [1:0] START_CODE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam logic [1:0] TA_RELEASED = 2'h3;
   localparam logic [4:0] HDR_LAST = 5'h0b;
   localparam logic [4:0] DATA_LAST = 5'h0f;
   localparam logic [5:0] FRAME_LAST = 6'h20;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [31:0] READ_DRIVE_MASK = 32'hfffc0000;
   localparam logic [31:0] WRITE_DRIVE_MASK = 32'hffffffff;
endpackage

// >>> rtl/smsl_if.sv
// the shared management data wire and management clock between station and device
// assumes an external pull-up: a released wire reads high
`timescale 1ns/1ps
interface smsl_if;
   logic mdc;
   logic st_out;
   logic st_oe;
   logic dv_out;
   logic dv_oe;
   logic mdio_line;
   // wired-and with the pull-up standing in for released drivers
   assign mdio_line = (st_oe ? st_out : 1'b1) & (dv_oe ? dv_out : 1'b1);
   modport station (output mdc, output st_out, output st_oe, input mdio_line);
   modport device (input mdc, input mdio_line, output dv_out, output dv_oe);
endinterface

// >>> rtl/smsl_station.sv
// management station: makes mdc by division and shifts one frame per request
// assumes the wire returns from the device asynchronously; it passes two flip-flops
`timescale 1ns/1ps
module smsl_station
   import smsl_pkg::*;
#(
   parameter logic [7:0] HALF_CYC = 8'(MDC_HALF_CYC)
)
(
   input wire logic clk_sys,
   input wire logic rst,
   smsl_if.station bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [4:0] req_phy,
   input wire logic [4:0] req_reg,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic busy
);
   logic dio_m_r, dio_s_r;
   logic busy_r, busy_nxt;
   logic mdc_r, mdc_nxt;
   logic [7:0] div_r, div_nxt;
   logic [5:0] bit_r, bit_nxt;
   logic [31:0] fr_r, fr_nxt;
   logic [31:0] msk_r, msk_nxt;
   logic [DATA_W-1:0] rsh_r, rsh_nxt;
   logic out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic rspv_r, rspv_nxt;

   wire [1:0] req_op = req_write ? OP_WRITE : OP_READ;
   wire [1:0] req_ta = req_write ? TA_WRITE : TA_RELEASED;
   wire [31:0] req_frame = {START_CODE, req_op, req_phy, req_reg, req_ta, req_wdata};
   wire [31:0] req_mask = req_write ? WRITE_DRIVE_MASK : READ_DRIVE_MASK;
   wire half_done = (div_r == HALF_CYC - 8'h01);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dio_m_r <= 1'b1;
         dio_s_r <= 1'b1;
      end else begin
         dio_m_r <= bus.mdio_line;
         dio_s_r <= dio_m_r;
      end
   end

   // each frame opens with one released mdc cycle, which also keeps the bus quiet after reset
   always_comb begin
      busy_nxt = busy_r;
      mdc_nxt = mdc_r;
      div_nxt = div_r;
      bit_nxt = bit_r;
      fr_nxt = fr_r;
      msk_nxt = msk_r;
      rsh_nxt = rsh_r;
      out_nxt = out_r;
      oe_nxt = oe_r;
      rspv_nxt = 1'b0;
      if (!busy_r) begin
         if (req_valid) begin
            busy_nxt = 1'b1;
            fr_nxt = req_frame;
            msk_nxt = req_mask;
            bit_nxt = 6'h00;
            div_nxt = 8'h00;
            mdc_nxt = 1'b0;
            oe_nxt = 1'b0;
         end
      end else if (half_done) begin
         div_nxt = 8'h00;
         mdc_nxt = ~mdc_r;
         if (!mdc_r) begin
            rsh_nxt = {rsh_r[DATA_W-2:0], dio_s_r};
         end else if (bit_r == FRAME_LAST) begin
            busy_nxt = 1'b0;
            oe_nxt = 1'b0;
            rspv_nxt = 1'b1;
         end else begin
            // new bit goes out on the falling edge, half a period before it is sampled
            bit_nxt = bit_r + 6'h01;
            out_nxt = fr_r[31];
            oe_nxt = msk_r[31];
            fr_nxt = {fr_r[30:0], 1'b1};
            msk_nxt = {msk_r[30:0], 1'b0};
         end
      end else begin
         div_nxt = div_r + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         mdc_r <= 1'b0;
         div_r <= 8'h00;
         bit_r <= 6'h00;
         fr_r <= 32'h00000000;
         msk_r <= 32'h00000000;
         rsh_r <= '0;
         out_r <= 1'b1;
         oe_r <= 1'b0;
         rspv_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         mdc_r <= mdc_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         fr_r <= fr_nxt;
         msk_r <= msk_nxt;
         rsh_r <= rsh_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         rspv_r <= rspv_nxt;
      end
   end

   assign bus.mdc = mdc_r;
   assign bus.st_out = out_r;
   assign bus.st_oe = oe_r;
   assign req_ready = ~busy_r;
   assign rsp_valid = rspv_r;
   assign rsp_rdata = rsh_r;
   assign busy = busy_r;
endmodule

// >>> test/smsl_monitor.sv
// assertions on the shared management wire and its clock
// assumes the station divider stays at its default of five clocks a half period
`timescale 1ns/1ps
module smsl_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mdc,
   input wire logic st_out,
   input wire logic st_oe,
   input wire logic dv_out,
   input wire logic dv_oe,
   input wire logic mdio_line
);
   logic mdc_d_r;
   logic [5:0] bit_r;
   logic [5:0] drv_r;
   wire mdc_rise = mdc & ~mdc_d_r;
   // bit_r counts mdc rises since the station took the wire, so field positions are known
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mdc_d_r <= 1'b0;
         bit_r <= 6'h00;
         drv_r <= 6'h00;
      end else begin
         mdc_d_r <= mdc;
         bit_r <= st_oe ? bit_r + 6'(mdc_rise) : 6'h00;
         drv_r <= dv_oe ? drv_r + 6'(mdc_rise) : 6'h00;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_no_contention: assert property (!(st_oe && dv_oe))
      else $error("both ends drive the wire");
   a_released_high: assert property (!st_oe && !dv_oe |-> mdio_line)
      else $error("released wire not high");
   a_start_code: assert property (mdc_rise && st_oe && bit_r < 6'h02 |-> mdio_line == bit_r[0])
      else $error("start code not zero then one");
   a_write_turn: assert property (mdc_rise && st_oe && bit_r inside {6'h0e, 6'h0f} |-> st_out == !bit_r[0])
      else $error("write turnaround not one then zero");
   a_read_turn: assert property ($rose(dv_oe) |-> !dv_out && $past(st_oe, 8) == 1'b0)
      else $error("read turnaround wrong");
   a_drive_length: assert property ($fell(dv_oe) |-> drv_r == 6'h11)
      else $error("device drove a wrong number of bits");
   a_data_settled: assert property (dv_oe && $changed(dv_out) |-> mdc)
      else $error("device changed data while clock low");
   a_mdc_half: assert property ($rose(mdc) |-> mdc [*5] ##1 !mdc)
      else $error("management clock high time wrong");
   cover property ($rose(dv_oe));
   cover property (mdc_rise && st_oe && bit_r == 6'h0f);
   cover property ($fell(st_oe) && !dv_oe);
endmodule

// >>> test/tb_phy_serial_management_slave.sv
// bench joining station and device across the management wire
// assumes the default divider; each frame takes about 330 system clocks
`timescale 1ns/1ps
module tb_phy_serial_management_slave;
   import smsl_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [4:0] req_phy = 5'h00;
   logic [4:0] req_reg = 5'h00;
   logic [15:0] req_wdata = 16'h0000;
   logic [2:0] straps = 3'h5;
   logic [4:0] loc_addr = 5'h00;
   logic loc_we = 1'b0;
   logic [15:0] loc_wdata = 16'h0000;
   logic req_ready, rsp_valid, busy, wr_pulse, rd_pulse, frame_drop, addr_valid;
   logic [15:0] rsp_rdata, loc_rdata, wr_data, last_wd;
   logic [4:0] wr_addr, last_wa;
   logic [2:0] own_addr;
   int n_fail = 0;
   int n_tests = 0;
   int n_wr, n_rd, n_oe, n_drop;
   smsl_if bus_if ();
   smsl_station i_smsl_station (.clk_sys(clk_sys), .rst(rst), .bus(bus_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_phy(req_phy), .req_reg(req_reg),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy));
   smsl_device i_smsl_device (.clk_sys(clk_sys), .rst(rst), .bus(bus_if), .bus_address_straps(straps),
      .loc_addr(loc_addr), .loc_rdata(loc_rdata), .loc_we(loc_we), .loc_wdata(loc_wdata),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .rd_pulse(rd_pulse),
      .frame_drop(frame_drop), .own_addr(own_addr), .addr_valid(addr_valid));
   smsl_monitor i_smsl_monitor (.clk_sys(clk_sys), .rst(rst), .mdc(bus_if.mdc), .st_out(bus_if.st_out),
      .st_oe(bus_if.st_oe), .dv_out(bus_if.dv_out), .dv_oe(bus_if.dv_oe), .mdio_line(bus_if.mdio_line));
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (wr_pulse === 1'b1) begin
         n_wr++;
         last_wa = wr_addr;
         last_wd = wr_data;
      end
      if (rd_pulse === 1'b1) n_rd++;
      if (bus_if.dv_oe === 1'b1) n_oe++;
      if (frame_drop === 1'b1) n_drop++;
   end
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         $display("BAD %0t %s", $time, m);
         n_fail++;
      end
   endtask
   // one full frame; entered and left at a falling edge
   task automatic frame(input logic w, input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] wd);
      int k;
      n_wr = 0;
      n_rd = 0;
      n_oe = 0;
      n_drop = 0;
      req_valid = 1'b1;
      req_write = w;
      req_phy = ph;
      req_reg = rg;
      req_wdata = wd;
      @(negedge clk_sys);
      req_valid = 1'b0;
      // the first mdc rise of a frame must find the wire still released
      for (k = 0; k < 20 && bus_if.mdc !== 1'b1; k++) @(negedge clk_sys);
      chk(bus_if.mdc === 1'b1 && busy === 1'b1 && req_ready === 1'b0 && bus_if.st_oe === 1'b0
         && bus_if.mdio_line === 1'b1, "no released lead bit");
      for (k = 0; k < 400 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
      if (k == 400) begin
         chk(1'b0, "frame hung");
         wrap_up();
      end
      chk(busy === 1'b0 && req_ready === 1'b1 && bus_if.mdc === 1'b0, "clock not parked after frame");
      // the device commits a write about two clocks before the station reports
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic t_strap();
      chk(addr_valid === 1'b1 && own_addr === 3'h5, "strap address");
      chk(bus_if.mdio_line === 1'b1, "idle wire level");
      straps = 3'h2;
      repeat (10) @(negedge clk_sys);
      chk(own_addr === 3'h5, "address followed straps");
   endtask
   task automatic t_write_read();
      logic [4:0] rs [3] = '{5'h00, 5'h1f, 5'h0a};
      logic [15:0] d;
      foreach (rs[i]) begin
         d = {rs[i], 6'h2a, ~rs[i]};
         frame(1'b1, 5'h05, rs[i], d);
         chk(n_wr == 1 && n_drop == 0 && last_wa === rs[i] && last_wd === d, "write not stored");
         frame(1'b0, 5'h05, rs[i], 16'h0000);
         chk(rsp_rdata === d && n_rd == 1 && n_oe > 0, "read back wrong");
      end
   endtask
   task automatic t_other_phy();
      logic [4:0] ps [3] = '{5'h04, 5'h0d, 5'h15};
      foreach (ps[i]) begin
         frame(1'b1, ps[i], 5'h0a, 16'hffff);
         chk(n_wr == 0 && n_oe == 0, "foreign write taken");
         frame(1'b0, ps[i], 5'h0a, 16'h0000);
         chk(n_oe == 0 && n_rd == 0 && rsp_rdata === 16'hffff, "foreign read answered");
      end
      frame(1'b0, 5'h05, 5'h0a, 16'h0000);
      chk(rsp_rdata === {5'h0a, 6'h2a, 5'h15}, "register disturbed");
   endtask
   task automatic t_local();
      loc_addr = 5'h13;
      loc_wdata = 16'h3c5a;
      loc_we = 1'b1;
      @(negedge clk_sys);
      loc_we = 1'b0;
      frame(1'b0, 5'h05, 5'h13, 16'h0000);
      chk(rsp_rdata === 16'h3c5a, "local write not seen on wire");
      loc_addr = 5'h1f;
      repeat (2) @(negedge clk_sys);
      chk(loc_rdata === {5'h1f, 6'h2a, 5'h00}, "wire write not seen locally");
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      repeat (8) @(negedge clk_sys);
      t_strap();
      t_write_read();
      t_other_phy();
      t_local();
      wrap_up();
   end
endmodule
